// File: hdl/ubt_pkg.sv
/*
  Constants for the serial transmit path and its baud timer: register
  indices, bit positions, reset values and frame lengths.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package ubt_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h10;
  localparam logic [7:0] IDX_IRQ_EN = 8'h11;
  localparam logic [7:0] IDX_RX_CTRL = 8'h13;
  localparam logic [7:0] IDX_TX_CTRL = 8'h15;
  localparam logic [7:0] IDX_HOLD = 8'h16;
  localparam logic [7:0] IDX_DIVISOR = 8'h17;
  localparam int ADDR_SHIFT = 2;

  // transmit_status_control fields
  localparam int TX_CLKSRC_BIT = 7;
  localparam int TX_NINE_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_EMPTY_BIT = 1;
  localparam int TX_D9_BIT = 0;
  // receive_status_control fields
  localparam int RX_SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RX_NINE_BIT = 6;
  localparam int RX_SREN_BIT = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  // flag and enable registers
  localparam int FLAG_TXE_BIT = 1;

  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // baud ticks per bit
  localparam logic [5:0] ASYNC_SUB_LAST = 6'h3F;
  localparam logic [1:0] SYNC_PHASE_LAST = 2'h3;

  // frame lengths in bits
  localparam logic [3:0] LEN_ASYNC8 = 4'hA;
  localparam logic [3:0] LEN_ASYNC9 = 4'hB;
  localparam logic [3:0] LEN_SYNC8 = 4'h8;
  localparam logic [3:0] LEN_SYNC9 = 4'h9;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_ZERO = 4'h0;
endpackage : ubt_pkg

// File: hdl/ubt_transmitter.sv
/*
  Serial port transmit path: baud timer, holding buffer, transmit
  shifter, asynchronous NRZ and synchronous master/slave transmission.
  Assumes an APB master on CLK, a core sleep level on the same clock,
  and an outside shift clock that is sampled through three flip-flops.
*/
// Design decision made here: register access over APB.
//
// Operation
// - sync master bit rate is clk/(4(div+1))
// - async bit lasts sixty-four baud ticks
// - free-running 8-bit baud timer, shared
// - divisor write clears baud timer at once
// - NRZ frame: start, 8/9 data, stop
// - no hardware parity; ninth bit only
// - asynchronous operation halts during sleep
// - clocked-mode bit 4 clear selects async
// - shifter reloads only after stop bit, or after the last data bit when clocked
// - transfer at baud tick sets empty flag
// - empty flag cleared only by buffer write
// - shifter-empty status bit, read only, no interrupt
// - shifting needs enable, data and baud tick, or the outside clock as slave
// - write to idle shifter passes straight through; here it loads at the next baud tick, at once only as slave
// - enable clear aborts and releases the pin
// - clock-source clear makes synchronous slave
// - slave keeps shifting during sleep
// - second queued word keeps flag clear
// - flag with enable wakes sleeping core
`timescale 1ns/1ps
module ubt_transmitter
  import ubt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SLEEP_MODE,
  output logic WAKE,
  output logic TX_IRQ,
  input wire logic TXCK_I,
  output logic TXCK_O,
  output logic TXCK_OE,
  input wire logic DT_I,
  output logic DT_O,
  output logic DT_OE
);
  logic [7:0] divisor_reg;
  logic [7:0] hold_reg;
  logic hold_valid_reg;
  logic irq_en_reg;
  logic serial_port_enable_reg, rx9_reg, sren_reg, continuous_receive_enable_reg;
  logic clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg, ninth_transmit_bit_reg;
  logic [7:0] timer_reg;
  logic [5:0] sub_reg;
  logic [1:0] phase_reg;
  logic [10:0] shift_reg;
  logic [3:0] left_reg;
  logic ck_s1_reg, ck_s2_reg, ck_s3_reg, dt_s1_reg, dt_s2_reg;

  logic setup_ph, wr_en, addr_ok;
  logic [7:0] idx;
  logic wr_div, wr_hold, wr_tx, wr_rx, wr_ie;
  logic run, slave, master, halt, tick, busy, load, bit_end, ck_fall;
  logic cut;

  // bus decode
  assign idx = {2'h0, PADDR[7:ADDR_SHIFT]};
  assign addr_ok = (PADDR[ADDR_SHIFT-1:0] == 2'h0) &&
                   (idx == IDX_FLAGS || idx == IDX_IRQ_EN || idx == IDX_RX_CTRL ||
                    idx == IDX_TX_CTRL || idx == IDX_HOLD || idx == IDX_DIVISOR);
  assign setup_ph = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign wr_div = wr_en && idx == IDX_DIVISOR;
  assign wr_hold = wr_en && idx == IDX_HOLD;
  assign wr_tx = wr_en && idx == IDX_TX_CTRL;
  assign wr_rx = wr_en && idx == IDX_RX_CTRL;
  assign wr_ie = wr_en && idx == IDX_IRQ_EN;
  // zero-wait slave; read data was captured in the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // modes
  assign run = serial_port_enable_reg && transmit_enable_reg;
  // slave when clocked and clock source clear
  assign slave = sync_reg && !clock_source_select_reg;
  assign master = sync_reg && clock_source_select_reg;
  // only the slave keeps running asleep
  assign halt = SLEEP_MODE && !slave;
  assign busy = left_reg != LEN_ZERO;
  // clearing either enable cuts the frame at that edge
  // so the pin and the shifter never outlive the enable by a cycle
  assign cut = (wr_tx && !PWDATA[TX_EN_BIT]) || (wr_rx && !PWDATA[RX_SERIAL_PORT_ENABLE_BIT]);

  // pin synchronisers; only stage two and three feed logic
  always_ff @(posedge CLK) begin
    if (RST) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      dt_s1_reg <= 1'b0;
      dt_s2_reg <= 1'b0;
    end else begin
      ck_s1_reg <= TXCK_I;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      dt_s1_reg <= DT_I;
      dt_s2_reg <= dt_s1_reg;
    end
  end
  // shift on the outside clock's falling edge
  assign ck_fall = ck_s3_reg && !ck_s2_reg;

  assign tick = !halt && timer_reg == divisor_reg;
  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_reg <= BYTE_ZERO;
    end else if (wr_div) begin
      timer_reg <= BYTE_ZERO;
    end else if (tick) begin
      timer_reg <= BYTE_ZERO;
    end else if (!halt) begin
      timer_reg <= timer_reg + 8'h01;
    end
  end

  // load needs enable, buffered data and a baud tick, except as slave
  // and an empty shifter, i.e. stop bit gone, or the last data bit when clocked
  assign load = run && hold_valid_reg && !busy && (slave || tick);

  // async: 64 ticks per bit; master: 4 ticks
  always_comb begin
    bit_end = 1'b0;
    if (run && busy) begin
      if (slave) begin
        bit_end = ck_fall;
      end else if (master) begin
        bit_end = tick && phase_reg == SYNC_PHASE_LAST;
      end else begin
        bit_end = tick && sub_reg == ASYNC_SUB_LAST;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || !run || load) begin
      sub_reg <= 6'h00;
      phase_reg <= 2'h0;
    end else if (busy && tick) begin
      sub_reg <= sub_reg + 6'h01;
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // shifter
  always_ff @(posedge CLK) begin
    // enable clear aborts and empties the shifter
    if (RST || !run || cut) begin
      shift_reg <= '1;
      left_reg <= LEN_ZERO;
    end else if (load) begin
      // clocked-mode bit clear gives the async frame
      if (!sync_reg) begin
        // start low, data, optional ninth, stop high
        // ninth bit is whatever software wrote
        shift_reg <= {1'b1, tx9_reg ? ninth_transmit_bit_reg : 1'b1, hold_reg, 1'b0};
        left_reg <= tx9_reg ? LEN_ASYNC9 : LEN_ASYNC8;
      end else begin
        shift_reg <= {2'h3, ninth_transmit_bit_reg, hold_reg};
        left_reg <= tx9_reg ? LEN_SYNC9 : LEN_SYNC8;
      end
    // lsb goes out first, ninth bit after the data byte
    end else if (bit_end) begin
      shift_reg <= {1'b1, shift_reg[10:1]};
      left_reg <= left_reg - LEN_ONE;
    end
  end

  // holding buffer; a new write in the transfer cycle keeps it full
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_reg <= BYTE_ZERO;
      hold_valid_reg <= 1'b0;
    end else if (wr_hold) begin
      hold_reg <= PWDATA[7:0];
      hold_valid_reg <= 1'b1;
    // idle shifter takes the word at the next tick, a slave at once
    // later words wait until the shifter drains
    end else if (load) begin
      hold_valid_reg <= 1'b0;
    end
  end

  // control registers; receive bits other than port enable only stored for the shared path
  always_ff @(posedge CLK) begin
    if (RST) begin
      serial_port_enable_reg <= 1'b0;
      rx9_reg <= 1'b0;
      sren_reg <= 1'b0;
      continuous_receive_enable_reg <= 1'b0;
    end else if (wr_rx) begin
      serial_port_enable_reg <= PWDATA[RX_SERIAL_PORT_ENABLE_BIT];
      rx9_reg <= PWDATA[RX_NINE_BIT];
      sren_reg <= PWDATA[RX_SREN_BIT];
      continuous_receive_enable_reg <= PWDATA[RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
    end
  end

  // ninth bit must be written before the data byte
  always_ff @(posedge CLK) begin
    if (RST) begin
      clock_source_select_reg <= 1'b0;
      tx9_reg <= 1'b0;
      transmit_enable_reg <= 1'b0;
      sync_reg <= 1'b0;
      ninth_transmit_bit_reg <= 1'b0;
    end else if (wr_tx) begin
      clock_source_select_reg <= PWDATA[TX_CLKSRC_BIT];
      tx9_reg <= PWDATA[TX_NINE_BIT];
      transmit_enable_reg <= PWDATA[TX_EN_BIT];
      sync_reg <= PWDATA[TX_SYNC_BIT];
      ninth_transmit_bit_reg <= PWDATA[TX_D9_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      divisor_reg <= DIVISOR_RST;
      irq_en_reg <= 1'b0;
    end else begin
      if (wr_div) begin
        divisor_reg <= PWDATA[7:0];
      end
      if (wr_ie) begin
        irq_en_reg <= PWDATA[FLAG_TXE_BIT];
      end
    end
  end

  // read data captured in setup so it stands from a flip-flop
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup_ph) begin
      PRDATA <= 32'h0000_0000;
      case (idx)
        // flag mirrors the buffer, only a buffer write clears it
        IDX_FLAGS: PRDATA[FLAG_TXE_BIT] <= !hold_valid_reg;
        IDX_IRQ_EN: PRDATA[FLAG_TXE_BIT] <= irq_en_reg;
        IDX_RX_CTRL: PRDATA[7:0] <= {serial_port_enable_reg, rx9_reg, sren_reg, continuous_receive_enable_reg, 4'h0};
        IDX_TX_CTRL: PRDATA[7:0] <= {clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg,
                                     2'h0, !busy, ninth_transmit_bit_reg};
        IDX_HOLD: PRDATA[7:0] <= hold_reg;
        IDX_DIVISOR: PRDATA[7:0] <= divisor_reg;
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  assign TX_IRQ = irq_en_reg && !hold_valid_reg;
  // empty flag with enable wakes a sleeping core
  assign WAKE = SLEEP_MODE && TX_IRQ;

  // pins
  always_comb begin
    TXCK_O = 1'b1;
    TXCK_OE = 1'b0;
    DT_O = 1'b1;
    DT_OE = 1'b0;
    // pin floats unless port and transmitter enabled
    if (run) begin
      if (!sync_reg) begin
        TXCK_OE = 1'b1;
        TXCK_O = busy ? shift_reg[0] : 1'b1;
      end else begin
        DT_OE = 1'b1;
        DT_O = shift_reg[0];
        TXCK_OE = master;
        TXCK_O = master && busy && phase_reg[1];
      end
    end
  end

  // checks
  // divisor write restarts timer
  a_div_restart: assert property (
    @(posedge CLK) disable iff (RST)
    wr_div |=> timer_reg == BYTE_ZERO)
    else $error("divisor write kept timer");

  a_tick_period: assert property (
    @(posedge CLK) disable iff (RST)
    tick |=> timer_reg == BYTE_ZERO)
    else $error("timer did not wrap at divisor");

  a_async_x64: assert property (
    @(posedge CLK) disable iff (RST)
    bit_end && !sync_reg |-> sub_reg == ASYNC_SUB_LAST)
    else $error("async bit not 64 ticks");

  a_master_four: assert property (
    @(posedge CLK) disable iff (RST)
    bit_end && master |-> tick && phase_reg == SYNC_PHASE_LAST)
    else $error("master bit not 4 ticks");

  a_start_low: assert property (
    @(posedge CLK) disable iff (RST)
    load && !sync_reg |=> TXCK_O == 1'b0 && TXCK_OE)
    else $error("no start bit");

  a_stop_high: assert property (
    @(posedge CLK) disable iff (RST)
    run && !sync_reg && left_reg == LEN_ONE |-> TXCK_O)
    else $error("stop bit not high");

  a_load_gate: assert property (
    @(posedge CLK) disable iff (RST)
    load |-> transmit_enable_reg && hold_valid_reg && !busy)
    else $error("load without cause");

  a_load_flag: assert property (
    @(posedge CLK) disable iff (RST)
    load && !wr_hold && !cut |=> !hold_valid_reg && busy)
    else $error("transfer left flag clear");

  a_flag_hold: assert property (
    @(posedge CLK) disable iff (RST)
    !hold_valid_reg && !wr_hold |=> !hold_valid_reg)
    else $error("flag cleared without write");

  a_abort_float: assert property (
    @(posedge CLK) disable iff (RST)
    !transmit_enable_reg |-> !TXCK_OE && !DT_OE && left_reg == LEN_ZERO)
    else $error("abort left pin driven");

  a_sleep_halt: assert property (
    @(posedge CLK) disable iff (RST)
    SLEEP_MODE && !slave |=> $stable(timer_reg) || $past(wr_div))
    else $error("timer ran asleep");

  a_slave_sleep: assert property (
    @(posedge CLK) disable iff (RST)
    run && slave && busy && ck_fall |=> left_reg == $past(left_reg) - LEN_ONE)
    else $error("slave missed a clock edge");

  // slave takes a word at once
  a_slave_pass: assert property (
    @(posedge CLK) disable iff (RST)
    run && slave && hold_valid_reg && !busy && !cut |=> busy && !hold_valid_reg)
    else $error("idle shifter did not take word");

  a_queue_wait: assert property (
    @(posedge CLK) disable iff (RST)
    hold_valid_reg && busy && !wr_hold |=> hold_valid_reg)
    else $error("queued word left early");

  a_sync_ninth: assert property (
    @(posedge CLK) disable iff (RST)
    load && sync_reg |=> shift_reg[8] == $past(ninth_transmit_bit_reg))
    else $error("ninth bit misplaced");

  a_idle_high: assert property (
    @(posedge CLK) disable iff (RST)
    run && !sync_reg && !busy |-> TXCK_O && TXCK_OE)
    else $error("idle line not high");
endmodule : ubt_transmitter

// File: testbench/testbench.sv
/*
  Self-checking bench for the transmit path: APB register access,
  asynchronous frames, master clock rate, abort, slave transfer in sleep.
  Assumes pull-ups on both serial pins and divisor 0 for async frames.
*/
`timescale 1ns/1ps
module testbench;
  import ubt_pkg::*;
  logic clk, rst, psel, penable, pwrite, sleep_mode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, wake, tx_irq, txck_o, txck_oe, dt_o, dt_oe;
  logic txck_w, dt_w, pck, async_on, nine, err;
  logic [8:0] sd;
  int num_errors, compares, cycles;
  time t0;
  assign txck_w = txck_oe ? txck_o : pck;
  assign dt_w = dt_oe ? dt_o : 1'b1;
  ubt_transmitter i_ubt_transmitter (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLEEP_MODE(sleep_mode), .WAKE(wake), .TX_IRQ(tx_irq), .TXCK_I(txck_w),
    .TXCK_O(txck_o), .TXCK_OE(txck_oe), .DT_I(dt_w), .DT_O(dt_o),
    .DT_OE(dt_oe));
  ubt_far_end i_ubt_far_end (.pin(txck_w), .dt(dt_w), .async_on(async_on),
    .nine(nine), .ck(pck));
  always #50 clk = ~clk;
  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdc
  task automatic frm(input logic [10:0] exp);
    while (i_ubt_far_end.frames.size() == 0) @(posedge clk);
    chk({21'h0, i_ubt_far_end.frames.pop_front()}, {21'h0, exp});
  endtask : frm
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, sleep_mode, async_on, nine} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_TX_CTRL, 32'h02);
    rdc(IDX_FLAGS, 32'h02);
    rdc(IDX_DIVISOR, 32'h00);
    apb(1'b0, 8'h01, 8'h00);
    chk({31'h0, err}, 32'h1);
    async_on <= 1'b1;
    wr(IDX_DIVISOR, 8'h00);
    wr(IDX_RX_CTRL, 8'h80);
    wr(IDX_HOLD, 8'hA5);
    wr(IDX_TX_CTRL, 8'h20);
    wr(IDX_HOLD, 8'h3C);
    rdc(IDX_FLAGS, 32'h00);
    frm({1'b0, 1'b1, 8'hA5, 1'b0});
    frm({1'b0, 1'b1, 8'h3C, 1'b0});
    rdc(IDX_FLAGS, 32'h02);
    // stop bit still runs after the far end has taken it
    repeat (64) @(posedge clk);
    rdc(IDX_TX_CTRL, 32'h22);
    nine <= 1'b1;
    wr(IDX_TX_CTRL, 8'h61);
    wr(IDX_HOLD, 8'h5A);
    frm({1'b1, 1'b1, 8'h5A, 1'b0});
    wr(IDX_HOLD, 8'h0F);
    repeat (100) @(posedge clk);
    wr(IDX_TX_CTRL, 8'h40);
    @(posedge clk);
    chk({31'h0, txck_oe}, 32'h0);
    rdc(IDX_TX_CTRL, 32'h42);
    async_on <= 1'b0;
    // let the far end finish the cut frame
    repeat (800) @(posedge clk);
    i_ubt_far_end.frames.delete();
    wr(IDX_DIVISOR, 8'h01);
    wr(IDX_TX_CTRL, 8'hB0);
    wr(IDX_HOLD, 8'h81);
    @(posedge txck_o);
    t0 = $time;
    @(posedge txck_o);
    chk(32'($time - t0), 32'd800);
    repeat (100) @(posedge clk);
    wr(IDX_TX_CTRL, 8'h00);
    wr(IDX_IRQ_EN, 8'h02);
    wr(IDX_TX_CTRL, 8'h70);
    wr(IDX_HOLD, 8'hC6);
    wr(IDX_HOLD, 8'h39);
    rdc(IDX_FLAGS, 32'h00);
    sleep_mode <= 1'b1;
    i_ubt_far_end.sync_clk(9, sd);
    chk({23'h0, sd}, {23'h0, 9'h0C6});
    i_ubt_far_end.sync_clk(9, sd);
    chk({23'h0, sd}, {23'h0, 9'h039});
    chk({31'h0, wake}, 32'h1);
    rdc(IDX_FLAGS, 32'h02);
    print_verdict();
  end
endmodule : testbench

// File: testbench/ubt_far_end.sv
/*
  Far side of the serial port: an asynchronous line receiver and an
  outside shift-clock master for synchronous slave transfers.
  Assumes the transmit/clock pin idles high through a pull-up.
*/
`timescale 1ns/1ps
module ubt_far_end #(
  parameter int BIT_NS = 6400
) (
  input wire logic pin,
  input wire logic dt,
  input wire logic async_on,
  input wire logic nine,
  output logic ck
);
  logic [10:0] frames[$];
  logic [10:0] v;
  int n;
  initial ck = 1'b1;
  always begin
    @(negedge pin);
    if (async_on) begin
      n = nine ? 11 : 10;
      v = '0;
      #(BIT_NS / 2);
      for (int i = 0; i < n; i++) begin
        v[i] = pin;
        // no wait after stop: next start may follow at once
        if (i < n - 1) begin
          #(BIT_NS);
        end
      end
      frames.push_back(v);
    end
  end
  // outside clock, stands high between frames
  task automatic sync_clk(input int nb, output logic [8:0] d);
    d = '0;
    #37;
    // the device moves to the next bit after each falling edge,
    // so each bit is taken just before that edge
    for (int i = 0; i < nb; i++) begin
      d[i] = dt;
      ck = 1'b0;
      #400;
      ck = 1'b1;
      #400;
    end
  endtask : sync_clk
endmodule : ubt_far_end
